// ===== rtl/err_mask_pkg.sv
package err_mask_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and layouts
  // ----------------------------------------------------------------------
  localparam logic [15:0] ERROR_FLAGS_OFS = 16'h0404;
  localparam logic [15:0] EVENT_IRQ_ENABLE_0_OFS = 16'h0405;
  localparam logic [31:0] ERROR_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] ERROR_FLAGS_IMPL = 32'h007f_ffff;
  localparam logic [31:0] INTERNAL_FAULT_BITS = 32'h0060_00be;
  localparam logic [31:0] EVENT_IRQ_ENABLE_0_RST = 32'h0000_4000;
  localparam logic [31:0] EVENT_IRQ_ENABLE_0_RW = 32'hffff_bfff;
  localparam int ADC_INIT_BIT = 0;
  localparam int ADC_CRC_BIT = 6;
  localparam int SAMPLE_RATE_FAULT_BIT = 8;
  localparam int CONV_SUMMARY_BIT = 9;
  localparam int RESET_COMPLETE_EN_BIT = 14;

  // ----------------------------------------------------------------------
  // Converter status summaries
  // ----------------------------------------------------------------------
  localparam int CONV_NUM = 4;
  localparam int CONV_REGS = 3;
  localparam int CONV_STATUS_W = 8;
  localparam int FAULT_NUM = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int SAMPLE_RATE_HZ = 4000;
  localparam int SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int RATE_TOL_CYC = 62;

  typedef enum logic [1:0] {
    RATE_WAIT = 2'b01,
    RATE_RUN = 2'b10
  } rate_state_t;

endpackage

// ===== rtl/blk_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface blk_link_if;
  logic drdy;
  logic rate_bad;
  logic [1:0] pulse_pins;
  logic [1:0] pulse_fall;

  modport core (output drdy, output pulse_pins,
    input rate_bad, input pulse_fall);
  modport rate_mon (input drdy, output rate_bad);
  modport edge_mon (input pulse_pins, output pulse_fall);
endinterface
`default_nettype wire

// ===== rtl/sample_rate_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sample_rate_monitor #(
  parameter int PERIOD_CYC = err_mask_pkg::SAMPLE_PERIOD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  blk_link_if.rate_mon lnk
);
  localparam logic [15:0] EARLY = 16'(PERIOD_CYC - err_mask_pkg::RATE_TOL_CYC);
  localparam logic [15:0] LATE = 16'(PERIOD_CYC + err_mask_pkg::RATE_TOL_CYC);

  err_mask_pkg::rate_state_t state_q;
  err_mask_pkg::rate_state_t state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic bad_q;
  logic bad_d;
  logic [15:0] gap;

  // Gap is the interval in cycles ending at this edge.
  assign gap = cnt_q + 16'h0001;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    bad_d = 1'b0;
    case (state_q)
      err_mask_pkg::RATE_WAIT:
      begin
        if (lnk.drdy)
        begin
          state_d = err_mask_pkg::RATE_RUN;
          cnt_d = 16'h0000;
        end
      end
      err_mask_pkg::RATE_RUN:
      begin
        if (lnk.drdy)
        begin
          bad_d = (gap < EARLY) || (gap > LATE);
          cnt_d = 16'h0000;
        end
        else if (cnt_q <= LATE)
        begin
          bad_d = (gap == LATE + 16'h0001);
          cnt_d = gap;
        end
      end
      default:
      begin
        state_d = err_mask_pkg::RATE_WAIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= err_mask_pkg::RATE_WAIT;
      cnt_q <= 16'h0000;
      bad_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bad_q <= bad_d;
    end
  end

  assign lnk.rate_bad = bad_q;

  AST_RATE_EARLY_FLAGGED: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (state_q == err_mask_pkg::RATE_RUN && lnk.drdy && gap < EARLY)
    |=> lnk.rate_bad)
    else $error("Early data-ready edge not flagged.");

  AST_RATE_GOOD_QUIET: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (state_q == err_mask_pkg::RATE_RUN && lnk.drdy && gap >= EARLY
      && gap <= LATE) |=> !lnk.rate_bad)
    else $error("Nominal data-ready interval flagged.");
endmodule
`default_nettype wire

// ===== rtl/pulse_fall_detect.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_fall_detect (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  blk_link_if.edge_mon lnk
);
  logic [1:0] prev_q;
  logic [1:0] fall_q;
  logic [1:0] fall_d;

  assign fall_d = prev_q & ~lnk.pulse_pins;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      prev_q <= 2'h0;
      fall_q <= 2'h0;
    end
    else
    begin
      prev_q <= lnk.pulse_pins;
      fall_q <= fall_d;
    end
  end

  assign lnk.pulse_fall = fall_q;

  AST_FALL_ONE_CYCLE: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    lnk.pulse_fall[0] |=> !lnk.pulse_fall[0])
    else $error("Pulse event lasted more than one cycle.");
endmodule
`default_nettype wire

// ===== rtl/error_status_and_irq_mask.sv
`timescale 1ns/10ps
`default_nettype none
module error_status_and_irq_mask #(
  parameter int SAMPLE_PERIOD_CYC = err_mask_pkg::SAMPLE_PERIOD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic adc_drdy_i,
  input wire logic adc_init_fail_i,
  input wire logic adc_crc_fail_i,
  input wire logic [7:0] internal_fault_i,
  input wire logic [95:0] conv_status_i,
  input wire logic pulse_out_first_i,
  input wire logic pulse_out_second_i,
  input wire logic [31:0] event_flags_i,
  input wire logic sample_valid_i,
  output logic sample_accept_o,
  output logic meas_update_en_o,
  output logic [1:0] pulse_issued_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic any_set(input logic [7:0] w);
    return |w;
  endfunction

  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  blk_link_if lnk ();

  assign lnk.drdy = adc_drdy_i;
  assign lnk.pulse_pins = {pulse_out_second_i, pulse_out_first_i};

  sample_rate_monitor #(
    .PERIOD_CYC(SAMPLE_PERIOD_CYC)
  ) u_rate (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .lnk(lnk)
  );

  pulse_fall_detect u_fall (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .lnk(lnk)
  );

  assign pulse_issued_o = lnk.pulse_fall;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire logic hit_err;
  wire logic hit_mask;
  wire logic wr_err;
  wire logic wr_mask;
  wire logic rd_err;
  wire logic rd_mask;

  assign hit_err = addr_hit(reg_addr_i, err_mask_pkg::ERROR_FLAGS_OFS);
  assign hit_mask = addr_hit(reg_addr_i,
                             err_mask_pkg::EVENT_IRQ_ENABLE_0_OFS);
  assign wr_err = reg_wr_i && hit_err;
  assign wr_mask = reg_wr_i && hit_mask;
  assign rd_err = reg_rd_i && hit_err;
  assign rd_mask = reg_rd_i && hit_mask;

  // ----------------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------------
  logic [11:0] conv_any;

  for (genvar i = 0; i < err_mask_pkg::CONV_NUM * err_mask_pkg::CONV_REGS;
       i++)
  begin : g_conv
    // Index is converter times three plus remote register number.
    assign conv_any[i] = any_set(
      conv_status_i[i*err_mask_pkg::CONV_STATUS_W +:
                    err_mask_pkg::CONV_STATUS_W]);
  end

  logic [31:0] err_q;
  wire logic [31:0] err_set;
  wire logic [31:0] err_clr;
  wire logic [31:0] err_d;

  assign err_set = {9'h000, internal_fault_i[7:6], conv_any,
                    lnk.rate_bad, internal_fault_i[5], adc_crc_fail_i,
                    internal_fault_i[4:0], adc_init_fail_i};
  assign err_clr = wr_err ? reg_wdata_i : 32'h0000_0000;
  // Set wins over a clear arriving in the same cycle.
  assign err_d = ((err_q & ~err_clr) | err_set)
                 & err_mask_pkg::ERROR_FLAGS_IMPL;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      err_q <= err_mask_pkg::ERROR_FLAGS_RST;
    else
      err_q <= err_d;
  end

  // ----------------------------------------------------------------------
  // Sample gating
  // ----------------------------------------------------------------------
  wire logic rate_fault;

  assign rate_fault = err_q[err_mask_pkg::SAMPLE_RATE_FAULT_BIT];
  assign sample_accept_o = sample_valid_i && !rate_fault;
  assign meas_update_en_o = !rate_fault;

  // ----------------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------------
  logic [31:0] mask_q;
  wire logic [31:0] mask_d;

  // Every bit but reset-complete is writable; that one is pinned high.
  assign mask_d = wr_mask
    ? ((reg_wdata_i & err_mask_pkg::EVENT_IRQ_ENABLE_0_RW)
       | err_mask_pkg::EVENT_IRQ_ENABLE_0_RST)
    : mask_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      mask_q <= err_mask_pkg::EVENT_IRQ_ENABLE_0_RST;
    else
      mask_q <= mask_d;
  end

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  logic irq_q;
  wire logic irq_d;

  // Each enable bit gates the event flag at the same position.
  assign irq_d = |(event_flags_i & mask_q);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign irq_o = irq_q;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rdata_q;
  wire logic [31:0] rdata_sel;

  assign rdata_sel = rd_err ? err_q : (rd_mask ? mask_q : 32'h0000_0000);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      rdata_q <= 32'h0000_0000;
    else if (reg_rd_i)
      rdata_q <= rdata_sel;
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_RATE_SETS_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    lnk.rate_bad |=> err_q[8])
    else $error("Rate fault did not set its flag.");

  AST_W1C_CLEARS: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (wr_err && reg_wdata_i[6] && !adc_crc_fail_i) |=> !err_q[6])
    else $error("Write one did not clear the CRC flag.");

  AST_SET_WINS: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (adc_init_fail_i && wr_err && reg_wdata_i[0]) |=> err_q[0])
    else $error("Clear beat a same-cycle start-up failure.");

  AST_STICKY_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (err_q[6] && !(wr_err && reg_wdata_i[6])) |=> err_q[6])
    else $error("CRC flag dropped without a clear.");

  AST_GATE_SAMPLES: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    err_q[8] |-> (!sample_accept_o && !meas_update_en_o))
    else $error("Samples passed while rate fault set.");

  AST_CONV_SUMMARY: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (|conv_status_i[7:0]) |=> err_q[9])
    else $error("Converter 0 status 0 summary not set.");

  AST_CONV3_SUMMARY: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (|conv_status_i[95:88]) |=> err_q[20])
    else $error("Converter 3 status 2 summary not set.");

  AST_RESET_EN_PINNED: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    wr_mask |=> mask_q[err_mask_pkg::RESET_COMPLETE_EN_BIT])
    else $error("Reset-complete enable not held at one.");

  AST_MASK_WRITE: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    wr_mask |=> (mask_q[31:26] == $past(reg_wdata_i[31:26])))
    else $error("Enable write not stored.");

  AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    (event_flags_i[14] && !wr_mask) |=> irq_o)
    else $error("Enabled event did not raise interrupt.");

  AST_IRQ_QUIET: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    ((event_flags_i & mask_q) == 32'h0000_0000) |=> !irq_o)
    else $error("Interrupt high with no enabled event.");

  AST_READ_ERR: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    rd_err |=> (reg_rdata_o == $past(err_q)))
    else $error("Error flag read returned wrong data.");

  AST_INIT_SETS: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    adc_init_fail_i |=> err_q[err_mask_pkg::ADC_INIT_BIT])
    else $error("Start-up failure did not set its flag.");

  AST_CRC_SETS: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    adc_crc_fail_i |=> err_q[err_mask_pkg::ADC_CRC_BIT])
    else $error("CRC failure did not set its flag.");

  AST_MASK_LOW_WRITE: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    wr_mask |=> (mask_q[13:0] == $past(reg_wdata_i[13:0])))
    else $error("Low enable bits not stored.");

  AST_MASK_MID_WRITE: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    wr_mask |=> (mask_q[25:15] == $past(reg_wdata_i[25:15])))
    else $error("Middle enable bits not stored.");

  AST_MASK_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    !wr_mask |=> $stable(mask_q))
    else $error("Enable register changed without a write.");

  AST_READ_MASK: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    rd_mask |=> (reg_rdata_o == $past(mask_q)))
    else $error("Enable read returned wrong data.");

  AST_SAMPLE_PASS: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i)
    !err_q[8] |-> (sample_accept_o == sample_valid_i))
    else $error("Sample refused while rate is healthy.");

endmodule
`default_nettype wire

// ===== tb/drdy_source.sv
`timescale 1ns/10ps
`default_nettype none
module drdy_source (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] gap_i,
  output logic drdy_o
);
  // ------------------------------------------------------------------
  // Converter chain model: one data-ready pulse every gap_i cycles.
  // ------------------------------------------------------------------
  logic [15:0] cnt_q;

  // The gap read each cycle lets the bench bend a single interval.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 16'h0000;
      drdy_o <= 1'b0;
    end
    else if (cnt_q + 16'h0001 >= gap_i)
    begin
      cnt_q <= 16'h0000;
      drdy_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      drdy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/error_status_and_irq_mask_tb.sv
`timescale 1ns/10ps
`default_nettype none
module error_status_and_irq_mask_tb;
  // ------------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic drdy;
  logic init_fail = 1'b0;
  logic crc_fail = 1'b0;
  logic [7:0] fault = 8'h00;
  logic [95:0] conv = 96'h0;
  logic [1:0] pins = 2'h0;
  logic [31:0] events = 32'h0000_0000;
  logic [15:0] gap = 16'h00c8;
  logic valid = 1'b1;
  logic accept;
  logic meas_en;
  logic irq;
  logic [1:0] issued;
  int errors = 0;
  int n_compared = 0;
  int cnt;
  int pos;
  logic [41:0] rows [10] = '{
    {8'h00, 1'b1, 1'b0, 32'h0000_0001}, {8'h00, 1'b0, 1'b1, 32'h0000_0040},
    {8'h01, 1'b0, 1'b0, 32'h0000_0002}, {8'h02, 1'b0, 1'b0, 32'h0000_0004},
    {8'h04, 1'b0, 1'b0, 32'h0000_0008}, {8'h08, 1'b0, 1'b0, 32'h0000_0010},
    {8'h10, 1'b0, 1'b0, 32'h0000_0020}, {8'h20, 1'b0, 1'b0, 32'h0000_0080},
    {8'h40, 1'b0, 1'b0, 32'h0020_0000}, {8'h80, 1'b0, 1'b0, 32'h0040_0000}};
  logic [16:0] rates [6] = '{{16'h00c8, 1'b0}, {16'h0106, 1'b0},
    {16'h008a, 1'b0}, {16'h0107, 1'b1}, {16'h0089, 1'b1}, {16'h0064, 1'b1}};

  always #20 ref_clk_i = ~ref_clk_i;

  drdy_source u_src (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .gap_i(gap),
    .drdy_o(drdy)
  );

  error_status_and_irq_mask #(
    .SAMPLE_PERIOD_CYC(200)
  ) u_dut (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr),
    .reg_wr_i(wr_en),
    .reg_rd_i(rd_en),
    .reg_wdata_i(wdata),
    .reg_rdata_o(rdata),
    .adc_drdy_i(drdy),
    .adc_init_fail_i(init_fail),
    .adc_crc_fail_i(crc_fail),
    .internal_fault_i(fault),
    .conv_status_i(conv),
    .pulse_out_first_i(pins[0]),
    .pulse_out_second_i(pins[1]),
    .event_flags_i(events),
    .sample_valid_i(valid),
    .sample_accept_o(accept),
    .meas_update_en_o(meas_en),
    .pulse_issued_o(issued),
    .irq_o(irq)
  );

  task automatic test_done;
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk_i);
    wr_en <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e,
    input string nm);
    @(posedge ref_clk_i);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk_i);
    rd_en <= 1'b0;
    @(negedge ref_clk_i);
    chk(nm, e, rdata);
  endtask

  task automatic apply(input logic [7:0] f, input logic i, c,
    input logic [95:0] s, input logic [31:0] e);
    @(posedge ref_clk_i);
    fault <= f;
    init_fail <= i;
    crc_fail <= c;
    conv <= s;
    @(posedge ref_clk_i);
    fault <= 8'h00;
    init_fail <= 1'b0;
    crc_fail <= 1'b0;
    conv <= 96'h0;
    rdchk(16'h0404, e, "flags");
    wr(16'h0404, e);
    rdchk(16'h0404, 32'h0000_0000, "flags_cleared");
  endtask

  task automatic wait_drdy;
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge ref_clk_i);
      if (drdy === 1'b1)
        break;
    end
    if (i == 400)
    begin
      errors++;
      test_done;
    end
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    foreach (rows[r])
      apply(rows[r][41:34], rows[r][33], rows[r][32], 96'h0,
        rows[r][31:0]);
    @(posedge ref_clk_i);
    init_fail <= 1'b1;
    wr(16'h0404, 32'h0000_0001);
    init_fail <= 1'b0;
    rdchk(16'h0404, 32'h0000_0001, "set_wins");
    wr(16'h0404, 32'h0000_0001);
    for (int k = 0; k < 12; k++)
      apply(8'h00, 1'b0, 1'b0, 96'h80 << (8 * k),
        32'h1 << (9 + k));
    rdchk(16'h0405, 32'h0000_4000, "enable_reset");
    wr(16'h0405, 32'h0000_0000);
    rdchk(16'h0405, 32'h0000_4000, "enable_ro");
    wr(16'h0405, 32'hffff_ffff);
    wr(16'h0406, 32'h0000_0000);
    rdchk(16'h0405, 32'hffff_ffff, "enable_rw");
    rdchk(16'h0406, 32'h0000_0000, "unmapped");
    for (int n = 0; n < 32; n++)
    begin
      wr(16'h0405, ~(32'h1 << n));
      @(posedge ref_clk_i);
      events <= 32'h1 << n;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("irq_masked", {31'h0, n == 14}, irq);
      wr(16'h0405, 32'hffff_ffff);
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("irq_enabled", 32'h1, irq);
      @(posedge ref_clk_i);
      events <= 32'h0000_0000;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("irq_cleared", 32'h0, irq);
    end
    for (int p = 0; p < 2; p++)
    begin
      @(posedge ref_clk_i);
      pins[p] <= 1'b1;
      @(posedge ref_clk_i);
      pins[p] <= 1'b0;
      cnt = 0;
      pos = 0;
      for (int j = 0; j < 6; j++)
      begin
        @(negedge ref_clk_i);
        if (issued[p] === 1'b1)
        begin
          cnt++;
          pos = j;
        end
      end
      chk("pulse_count", 32'h1, cnt);
      chk("pulse_delay", 32'h1, pos);
    end
    foreach (rates[r])
    begin
      wait_drdy;
      gap <= rates[r][16:1];
      wait_drdy;
      gap <= 16'h00c8;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("accept", {31'h0, ~rates[r][0]}, accept);
      chk("meas_update", {31'h0, ~rates[r][0]}, meas_en);
      rdchk(16'h0404, {23'h0, rates[r][0], 8'h00}, "rate_flag");
      wait_drdy;
      wr(16'h0404, 32'h0000_0100);
      rdchk(16'h0404, 32'h0000_0000, "rate_cleared");
      chk("meas_resumed", 32'h1, meas_en);
    end
    @(posedge ref_clk_i);
    valid <= 1'b0;
    @(negedge ref_clk_i);
    chk("accept_idle", 32'h0, accept);
    @(posedge ref_clk_i);
    valid <= 1'b1;
    @(negedge ref_clk_i);
    chk("accept_live", 32'h1, accept);
    @(posedge ref_clk_i);
    fault <= 8'h01;
    events <= 32'hffff_ffff;
    @(posedge ref_clk_i);
    fault <= 8'h00;
    rdchk(16'h0404, 32'h0000_0002, "fault_seen");
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    events <= 32'h0000_0000;
    sys_rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("irq_reset", 32'h0, irq);
    rdchk(16'h0404, 32'h0000_0000, "flags_reset");
    rdchk(16'h0405, 32'h0000_4000, "enable_reset2");
    test_done;
  end
endmodule
`default_nettype wire
